/* File: include/flash_status_pkg.sv */
// constants for the serial flash status, write-latch and protection block
// assumes a byte-wide command protocol on a serial link, opcode first, msb first
package flash_status_pkg;
  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_WRITE_RELOCK = 8'h04;
  localparam logic [7:0] OP_VOL_UNLOCK = 8'h50;
  localparam logic [7:0] OP_STATUS_LO = 8'h05;
  localparam logic [7:0] OP_STATUS_HI = 8'h35;
  localparam logic [7:0] OP_STATUS_UPDATE = 8'h01;
  localparam logic [7:0] OP_ID_READOUT = 8'h9F;
  localparam logic [7:0] OP_LEGACY_ID = 8'h90;
  localparam logic [7:0] OP_TWO_LANE_ID = 8'h92;
  localparam logic [7:0] OP_FOUR_LANE_ID = 8'h94;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_SUSPEND_A = 8'h75;
  localparam logic [7:0] OP_SUSPEND_B = 8'hB0;
  localparam logic [7:0] OP_RESUME_A = 8'h7A;
  localparam logic [7:0] OP_RESUME_B = 8'h30;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_TWO_LANE_PROGRAM = 8'hA2;
  localparam logic [7:0] OP_FOUR_LANE_PROGRAM = 8'h32;
  localparam logic [7:0] OP_OTP_PROGRAM = 8'h42;
  localparam logic [7:0] OP_PAGE_CLEAR = 8'h81;
  localparam logic [7:0] OP_FOUR_KB_CLEAR = 8'h20;
  localparam logic [7:0] OP_BLOCK32_CLEAR = 8'h52;
  localparam logic [7:0] OP_BLOCK64_CLEAR = 8'hD8;
  localparam logic [7:0] OP_OTP_CLEAR = 8'h44;
  localparam logic [7:0] OP_CHIP_CLEAR_A = 8'h60;
  localparam logic [7:0] OP_CHIP_CLEAR_B = 8'hC7;
  // ==========================================================
  // status word layout
  localparam int BUSY_BIT = 0;
  localparam int WLATCH_BIT = 1;
  localparam int PROTECT_LSB = 2;
  localparam int LOCK_LO_BIT = 7;
  localparam int LOCK_HI_BIT = 8;
  localparam int QUAD_BIT = 9;
  localparam int PROG_HALT_BIT = 10;
  localparam int OTP_LSB = 11;
  localparam int CMP_BIT = 14;
  localparam int ERASE_HALT_BIT = 15;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [4:0] PROTECT_NONE = 5'h00;
  // ==========================================================
  // security region address codes, bits 15..9
  localparam logic [6:0] REGION1_CODE = 7'h08;
  localparam logic [6:0] REGION2_CODE = 7'h10;
  localparam logic [6:0] REGION3_CODE = 7'h18;
  // ==========================================================
  // frame positions in rising link clock edges
  localparam logic [7:0] EDGE_OPCODE = 8'h08;
  localparam logic [7:0] EDGE_ONE_BYTE = 8'h10;
  localparam logic [7:0] EDGE_TWO_BYTES = 8'h18;
  localparam logic [7:0] EDGE_ADDRESS = 8'h20;
  localparam logic [7:0] EDGE_CAPTURE_END = 8'h28;
  localparam logic [7:0] LAST_A0_SINGLE = 8'h1F;
  localparam logic [7:0] LAST_A0_DUAL = 8'h13;
  localparam logic [7:0] LAST_A0_QUAD = 8'h0D;
  localparam logic [7:0] START_DUAL = 8'h18;
  localparam logic [7:0] START_QUAD = 8'h10;
  // ==========================================================
  // self-timed cycles
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int STATUS_CYCLE_NS = 1000;
  localparam int PROGRAM_NS = 2000;
  localparam int ERASE_NS = 4000;
  localparam int TIMER_W = 12;
  localparam int STATUS_CYCLES = (STATUS_CYCLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int PROGRAM_CYCLES = (PROGRAM_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int ERASE_CYCLES = (ERASE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  typedef enum logic [1:0] {KIND_STATUS, KIND_PROGRAM, KIND_ERASE} op_kind_e;
endpackage

/* File: verilog/flash_status_core.sv */
// serial flash status word, write latch, protection and identification readout
// assumes a host that frames commands with chip select and clocks the link itself
`timescale 1ns/1ps
`default_nettype none
// Function
// - 9Fh returns maker byte then two part bytes, one to three read.
// - 90h/92h/94h return ids after address; dual and quad take a dummy byte.
// - write unlock sets the write latch; host issues it before every change except a volatile update.
// - write relock in a bare opcode frame clears the write latch.
// - latch clears at power-up and on completion of every timed program, erase or update.
// - volatile unlock keeps the latch; an update in the very next frame skips the timed cycle.
// - 05h shifts out bits 7..0, 35h bits 15..8, upper lanes ignored.
// - status readout works any time, including during busy cycles.
// - status layout busy, latch, protect, locks, quad, program halt, otp, complement, erase halt.
// - busy reads 1 during program, erase or update, else 0.
// - with latch clear, program and erase are rejected, and update unless it follows volatile unlock.
// - protect bits writable by update only outside hardware protection.
// - whole-array erase runs only when protect bits are all zero.
// - lock bits 00 soft, 01 guard pin, 10 and 11 until power.
// - power cycle returns the power-lockdown lock code to software code.
// - quad enable 0 makes shared pin IO2 the guard; 1 makes data lanes.
// - otp lock bits set individually, clear only at reset, region becomes read-only.
// - protect complement bit defaults 0 and sits at bit 14, in the upper byte.
// - suspend sets erase-halted or program-halted; both read-only.
// - either resume opcode and power cycle clear both halted flags.
// - security region needs high address zero and a valid region code.
// - dual output sends four clocks per byte, odd bits on lane one.
module flash_status_core #(
  parameter logic [7:0] MAKER_ID = 8'hA5, // arbitrary value
  parameter logic [15:0] PART_ID = 16'h3C17 // arbitrary value
) (
  input wire logic CLOCK_IN,
  input wire logic NRST_IN,
  input wire logic SCLK_IN,
  input wire logic CS_N_IN,
  input wire logic IO0_IN,
  output logic IO0_OUT,
  output logic IO0_OE_OUT,
  input wire logic IO1_IN,
  output logic IO1_OUT,
  output logic IO1_OE_OUT,
  input wire logic IO2_IN,
  output logic IO2_OUT,
  output logic IO2_OE_OUT,
  input wire logic IO3_IN,
  output logic IO3_OUT,
  output logic IO3_OE_OUT,
  output logic [15:0] STATUS_WORD_OUT
);
  // ==========================================================
  // link domain: frame capture on rising link clock
  logic in_frame;
  logic [7:0] edge_cnt;
  logic [7:0] opcode;
  logic [31:0] shift;
  logic id_swap;
  logic req_s1;
  logic req_s2;
  logic ack;
  logic [15:0] link_status;
  logic req;
  logic [15:0] shadow;
  logic [3:0] lane_out;
  logic [3:0] lane_oe;
  // chip select high ends the frame without needing a link clock edge
  always_ff @(posedge SCLK_IN or posedge CS_N_IN)
  begin
    if (CS_N_IN)
      in_frame <= 1'b0;
    else
      in_frame <= 1'b1;
  end
  wire [7:0] cur_cnt = in_frame ? edge_cnt : 8'h00;
  wire [7:0] next_edge_cnt = (cur_cnt == 8'hFF) ? cur_cnt : cur_cnt + 8'h01;
  wire [7:0] next_opcode = in_frame ? {opcode[6:0], IO0_IN} : {7'h00, IO0_IN};
  wire shift_on = in_frame && cur_cnt >= flash_status_pkg::EDGE_OPCODE
    && cur_cnt < flash_status_pkg::EDGE_CAPTURE_END;
  wire [7:0] a0_edge = (opcode == flash_status_pkg::OP_TWO_LANE_ID) ? flash_status_pkg::LAST_A0_DUAL
    : (opcode == flash_status_pkg::OP_FOUR_LANE_ID) ? flash_status_pkg::LAST_A0_QUAD
    : flash_status_pkg::LAST_A0_SINGLE;
  // frame registers hold after chip select rises, so the core reads them stable
  always_ff @(posedge SCLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      edge_cnt <= 8'h00;
      opcode <= 8'h00;
      shift <= 32'h0000_0000;
      id_swap <= 1'b0;
    end
    else
    begin
      edge_cnt <= next_edge_cnt;
      if (cur_cnt < flash_status_pkg::EDGE_OPCODE)
        opcode <= next_opcode;
      if (!in_frame)
        shift <= 32'h0000_0000;
      else if (shift_on)
        shift <= {shift[30:0], IO0_IN};
      if (in_frame && cur_cnt == a0_edge)
        id_swap <= IO0_IN;
    end
  end
  // status word handshake: shadow only moves once the link has taken the last one
  always_ff @(posedge SCLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      ack <= 1'b0;
      link_status <= flash_status_pkg::STATUS_RESET;
    end
    else
    begin
      req_s1 <= req;
      req_s2 <= req_s1;
      if (req_s2 != ack)
      begin
        link_status <= shadow;
        ack <= req_s2;
      end
    end
  end
  // ==========================================================
  // link domain: readout on falling link clock
  wire rd_lo = opcode == flash_status_pkg::OP_STATUS_LO;
  wire rd_hi = opcode == flash_status_pkg::OP_STATUS_HI;
  wire rd_jedec = opcode == flash_status_pkg::OP_ID_READOUT;
  wire rd_leg = opcode == flash_status_pkg::OP_LEGACY_ID;
  wire rd_dual = opcode == flash_status_pkg::OP_TWO_LANE_ID;
  wire rd_quad = opcode == flash_status_pkg::OP_FOUR_LANE_ID;
  wire rd_any = rd_lo || rd_hi || rd_jedec || rd_leg || rd_dual || rd_quad;
  wire [7:0] start_edge = rd_leg ? flash_status_pkg::EDGE_ADDRESS : rd_dual ? flash_status_pkg::START_DUAL
    : rd_quad ? flash_status_pkg::START_QUAD : flash_status_pkg::EDGE_OPCODE;
  wire out_on = in_frame && rd_any && edge_cnt >= start_edge;
  wire [7:0] idx = edge_cnt - start_edge;
  wire [7:0] byte_num = rd_quad ? {1'b0, idx[7:1]} : rd_dual ? {2'b00, idx[7:2]} : {3'b000, idx[7:3]};
  wire [2:0] bit_pos = rd_quad ? {idx[0], 2'b00} : rd_dual ? {idx[1:0], 1'b0} : idx[2:0];
  wire [1:0] jedec_num = 2'(byte_num % 8'h03);
  wire [7:0] jedec_byte = (jedec_num == 2'h0) ? MAKER_ID : (jedec_num == 2'h1) ? PART_ID[15:8] : PART_ID[7:0];
  wire [7:0] legacy_byte = (byte_num[0] ^ id_swap) ? PART_ID[7:0] : MAKER_ID;
  wire [7:0] out_byte = rd_lo ? link_status[7:0] : rd_hi ? link_status[15:8]
    : rd_jedec ? jedec_byte : legacy_byte;
  wire [7:0] out_shifted = out_byte << bit_pos;
  wire quad_lanes = link_status[flash_status_pkg::QUAD_BIT];
  // quad pairs lanes 3..0 with bits 7..4; dual puts odd bits on lane 1
  wire [3:0] next_lane_out = rd_quad ? out_shifted[7:4] : rd_dual ? {2'b00, out_shifted[7:6]}
    : {2'b00, out_shifted[7], 1'b0};
  wire [3:0] next_lane_oe = !out_on ? 4'h0 : rd_quad ? (quad_lanes ? 4'hF : 4'h3)
    : rd_dual ? 4'h3 : 4'h2;
  always_ff @(negedge SCLK_IN or posedge CS_N_IN or negedge NRST_IN)
  begin
    if (!NRST_IN || CS_N_IN)
    begin
      lane_out <= 4'h0;
      lane_oe <= 4'h0;
    end
    else
    begin
      lane_out <= next_lane_out;
      lane_oe <= next_lane_oe;
    end
  end
  assign IO0_OUT = lane_out[0];
  assign IO1_OUT = lane_out[1];
  assign IO2_OUT = lane_out[2];
  assign IO3_OUT = lane_out[3];
  assign IO0_OE_OUT = lane_oe[0];
  assign IO1_OE_OUT = lane_oe[1];
  assign IO2_OE_OUT = lane_oe[2];
  assign IO3_OE_OUT = lane_oe[3];
  // ==========================================================
  // core domain: synchronisers and command decode
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic wp_s1;
  logic wp_s2;
  logic ack_s1;
  logic ack_s2;
  always_ff @(posedge CLOCK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      {cs_s1, cs_s2, cs_s3} <= 3'h7;
      {wp_s1, wp_s2} <= 2'h3;
      {ack_s1, ack_s2} <= 2'h0;
    end
    else
    begin
      {cs_s1, cs_s2, cs_s3} <= {CS_N_IN, cs_s1, cs_s2};
      {wp_s1, wp_s2} <= {IO2_IN, wp_s1};
      {ack_s1, ack_s2} <= {ack, ack_s1};
    end
  end
  logic busy;
  logic write_latch_flag;
  logic [4:0] protect;
  logic lock_lo;
  logic lock_hi;
  logic quad_en;
  logic prog_halt;
  logic erase_halt;
  logic [2:0] otp_lock;
  logic cmp;
  logic vol_armed;
  logic reset_armed;
  logic [flash_status_pkg::TIMER_W-1:0] timer;
  flash_status_pkg::op_kind_e kind;
  logic [15:0] status_word;
  wire frame_end = cs_s2 && !cs_s3;
  wire bare = edge_cnt == flash_status_pkg::EDGE_OPCODE;
  wire is_unlock = frame_end && bare && opcode == flash_status_pkg::OP_WRITE_UNLOCK;
  wire is_relock = frame_end && bare && opcode == flash_status_pkg::OP_WRITE_RELOCK;
  wire is_vol = frame_end && bare && opcode == flash_status_pkg::OP_VOL_UNLOCK;
  wire is_arm = frame_end && bare && opcode == flash_status_pkg::OP_RESET_ARM;
  wire is_reset = frame_end && bare && opcode == flash_status_pkg::OP_RESET && reset_armed;
  wire is_suspend = frame_end && bare
    && (opcode == flash_status_pkg::OP_SUSPEND_A || opcode == flash_status_pkg::OP_SUSPEND_B);
  wire is_resume = frame_end && bare
    && (opcode == flash_status_pkg::OP_RESUME_A || opcode == flash_status_pkg::OP_RESUME_B);
  wire is_chip = frame_end && bare
    && (opcode == flash_status_pkg::OP_CHIP_CLEAR_A || opcode == flash_status_pkg::OP_CHIP_CLEAR_B);
  wire upd_one = edge_cnt == flash_status_pkg::EDGE_ONE_BYTE;
  wire upd_two = edge_cnt == flash_status_pkg::EDGE_TWO_BYTES;
  wire is_update = frame_end && opcode == flash_status_pkg::OP_STATUS_UPDATE && (upd_one || upd_two);
  wire otp_erase = opcode == flash_status_pkg::OP_OTP_CLEAR;
  wire otp_prog = opcode == flash_status_pkg::OP_OTP_PROGRAM;
  wire is_erase = frame_end && edge_cnt == flash_status_pkg::EDGE_ADDRESS
    && (opcode == flash_status_pkg::OP_PAGE_CLEAR || opcode == flash_status_pkg::OP_FOUR_KB_CLEAR
    || opcode == flash_status_pkg::OP_BLOCK32_CLEAR || opcode == flash_status_pkg::OP_BLOCK64_CLEAR || otp_erase);
  wire is_program = frame_end && edge_cnt > flash_status_pkg::EDGE_ADDRESS
    && (opcode == flash_status_pkg::OP_PAGE_PROGRAM || opcode == flash_status_pkg::OP_TWO_LANE_PROGRAM
    || opcode == flash_status_pkg::OP_FOUR_LANE_PROGRAM || otp_prog);
  // address sits low for erase frames, one byte up once program data has followed
  wire [23:0] addr = is_program ? shift[31:8] : shift[23:0];
  wire high_zero = addr[23:16] == 8'h00;
  wire [2:0] region_hit = {addr[15:9] == flash_status_pkg::REGION3_CODE,
    addr[15:9] == flash_status_pkg::REGION2_CODE, addr[15:9] == flash_status_pkg::REGION1_CODE};
  wire region_ok = high_zero && (region_hit & ~otp_lock) != 3'h0;
  wire otp_refused = (otp_erase || otp_prog) && !region_ok;
  wire guard_high = quad_en || wp_s2;
  wire write_lock = lock_hi || (lock_lo && !guard_high);
  wire halted = prog_halt || erase_halt;
  wire start_update = is_update && !busy && (write_latch_flag || vol_armed) && !write_lock;
  wire nv_update = start_update && !vol_armed;
  wire start_prog = is_program && write_latch_flag && !busy && !halted && !otp_refused;
  wire start_erase = write_latch_flag && !busy && !halted
    && ((is_erase && !otp_refused) || (is_chip && protect == flash_status_pkg::PROTECT_NONE));
  wire do_suspend = is_suspend && busy && kind != flash_status_pkg::KIND_STATUS;
  wire do_resume = is_resume && halted;
  wire op_done = busy && timer == flash_status_pkg::TIMER_W'(1);
  wire [7:0] upd_lo = upd_two ? shift[15:8] : shift[7:0];
  wire [7:0] upd_hi = upd_two ? shift[7:0] : 8'h00;
  wire [flash_status_pkg::TIMER_W-1:0] load = start_erase ? flash_status_pkg::TIMER_W'(flash_status_pkg::ERASE_CYCLES)
    : start_prog ? flash_status_pkg::TIMER_W'(flash_status_pkg::PROGRAM_CYCLES)
    : flash_status_pkg::TIMER_W'(flash_status_pkg::STATUS_CYCLES);
  // ==========================================================
  // core domain: self-timed cycle and latch
  always_ff @(posedge CLOCK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      busy <= 1'b0;
      timer <= '0;
      kind <= flash_status_pkg::KIND_STATUS;
    end
    else if (is_reset)
      busy <= 1'b0;
    else if (nv_update || start_prog || start_erase)
    begin
      busy <= 1'b1;
      timer <= load;
      kind <= start_erase ? flash_status_pkg::KIND_ERASE
        : start_prog ? flash_status_pkg::KIND_PROGRAM : flash_status_pkg::KIND_STATUS;
    end
    else if (do_suspend)
      busy <= 1'b0;
    else if (do_resume)
      busy <= 1'b1;
    else if (busy)
    begin
      timer <= timer - flash_status_pkg::TIMER_W'(1);
      if (op_done)
        busy <= 1'b0;
    end
  end
  always_ff @(posedge CLOCK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      write_latch_flag <= 1'b0;
    else if (is_unlock && !busy)
      write_latch_flag <= 1'b1;
    else if (is_relock || op_done || is_reset)
      write_latch_flag <= 1'b0;
  end
  always_ff @(posedge CLOCK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      vol_armed <= 1'b0;
      reset_armed <= 1'b0;
    end
    else if (frame_end)
    begin
      vol_armed <= is_vol;
      reset_armed <= is_arm;
    end
  end
  // ==========================================================
  // core domain: status fields
  always_ff @(posedge CLOCK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      protect <= flash_status_pkg::STATUS_RESET[flash_status_pkg::PROTECT_LSB +: 5];
      lock_lo <= flash_status_pkg::STATUS_RESET[flash_status_pkg::LOCK_LO_BIT];
      lock_hi <= flash_status_pkg::STATUS_RESET[flash_status_pkg::LOCK_HI_BIT];
      quad_en <= flash_status_pkg::STATUS_RESET[flash_status_pkg::QUAD_BIT];
      otp_lock <= flash_status_pkg::STATUS_RESET[flash_status_pkg::OTP_LSB +: 3];
      cmp <= flash_status_pkg::STATUS_RESET[flash_status_pkg::CMP_BIT];
    end
    else if (start_update)
    begin
      protect <= upd_lo[flash_status_pkg::PROTECT_LSB +: 5];
      lock_lo <= upd_lo[flash_status_pkg::LOCK_LO_BIT];
      lock_hi <= upd_hi[flash_status_pkg::LOCK_HI_BIT - 8];
      quad_en <= upd_hi[flash_status_pkg::QUAD_BIT - 8];
      otp_lock <= otp_lock | upd_hi[flash_status_pkg::OTP_LSB - 8 +: 3];
      cmp <= upd_hi[flash_status_pkg::CMP_BIT - 8];
    end
  end
  always_ff @(posedge CLOCK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      prog_halt <= 1'b0;
      erase_halt <= 1'b0;
    end
    else if (do_suspend)
    begin
      prog_halt <= kind == flash_status_pkg::KIND_PROGRAM;
      erase_halt <= kind == flash_status_pkg::KIND_ERASE;
    end
    else if (is_resume || is_reset)
    begin
      prog_halt <= 1'b0;
      erase_halt <= 1'b0;
    end
  end
  always_comb
  begin
    status_word = flash_status_pkg::STATUS_RESET;
    status_word[flash_status_pkg::BUSY_BIT] = busy;
    status_word[flash_status_pkg::WLATCH_BIT] = write_latch_flag;
    status_word[flash_status_pkg::PROTECT_LSB +: 5] = protect;
    status_word[flash_status_pkg::LOCK_LO_BIT] = lock_lo;
    status_word[flash_status_pkg::LOCK_HI_BIT] = lock_hi;
    status_word[flash_status_pkg::QUAD_BIT] = quad_en;
    status_word[flash_status_pkg::PROG_HALT_BIT] = prog_halt;
    status_word[flash_status_pkg::OTP_LSB +: 3] = otp_lock;
    status_word[flash_status_pkg::CMP_BIT] = cmp;
    status_word[flash_status_pkg::ERASE_HALT_BIT] = erase_halt;
  end
  // one word in flight at a time; a change made meanwhile goes on the next round
  always_ff @(posedge CLOCK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      req <= 1'b0;
      shadow <= flash_status_pkg::STATUS_RESET;
      STATUS_WORD_OUT <= flash_status_pkg::STATUS_RESET;
    end
    else
    begin
      STATUS_WORD_OUT <= status_word;
      if (req == ack_s2 && shadow != status_word)
      begin
        shadow <= status_word;
        req <= ~req;
      end
    end
  end
  // ==========================================================
  // checks
  // busy rises one cycle after the start and must fall exactly one cycle time later
  localparam int STATUS_LEN = flash_status_pkg::STATUS_CYCLES;
  sequence update_taken;
    nv_update ##1 busy;
  endsequence
  AST_RELOCK_CLEARS: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    is_relock |=> !write_latch_flag) else $error("relock left the write latch set");
  AST_UNLOCK_SETS: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    is_unlock && !busy && !is_reset |=> write_latch_flag) else $error("unlock did not set the write latch");
  AST_VOL_KEEPS_LATCH: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    is_vol && !op_done |=> write_latch_flag == $past(write_latch_flag)) else $error("volatile unlock moved the write latch");
  AST_UPDATE_CYCLE: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    update_taken |-> ##STATUS_LEN (!busy && $past(busy))) else $error("update busy cycle length wrong");
  AST_DONE_CLEARS_LATCH: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    op_done |=> !write_latch_flag && !busy) else $error("completion left latch or busy set");
  AST_NO_LATCH_REJECT: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    (is_update || is_program || is_erase) && !write_latch_flag && !vol_armed && !busy |=> !busy && $stable(protect))
    else $error("write command taken without the latch");
  AST_LOCK_BLOCKS: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    is_update && write_lock |=> $stable(status_word[15:2]) && busy == $past(busy))
    else $error("blocked update changed status");
  AST_OTP_STICKY: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    ##1 ((otp_lock & $past(otp_lock)) == $past(otp_lock))) else $error("otp lock bit cleared");
  AST_CHIP_PROTECTED: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    is_chip && protect != flash_status_pkg::PROTECT_NONE && !busy |=> !busy)
    else $error("whole-array erase ran under protection");
  AST_RESUME_CLEARS: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    is_resume |=> !prog_halt && !erase_halt) else $error("resume left a halted flag");
  AST_SUSPEND_FLAGS: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    do_suspend && kind == flash_status_pkg::KIND_ERASE |=> erase_halt && !busy)
    else $error("erase suspend did not flag");
endmodule
`default_nettype wire

/* File: tb/flash_host_model.sv */
// host side of the serial link: frames commands and collects read bits
// assumes the device samples on rising link clock and shifts out on falling
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in
);
  // ==========================================================
  // frame driver
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // link clock stands still outside frames; released data line toggles
  task automatic frame(input logic [31:0] tx, input int ntx, input int nrx, output logic [23:0] rx);
    rx = 24'h00_0000;
    cs_n_out = 1'b0;
    for (int i = 0; i < ntx + nrx; i++)
    begin
      mosi_out = (i < ntx) ? tx[31 - i] : ~mosi_out;
      #7.5 sclk_out = 1'b1;
      if (i >= ntx) rx = {rx[22:0], miso_in};
      #7.5 sclk_out = 1'b0;
    end
    #7.5 cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    // gap well above the minimum idle between frames
    #40;
  endtask
endmodule
`default_nettype wire

/* File: tb/flash_status_and_write_enable_tb_top.sv */
// self-checking bench for the status word and write latch block
// assumes the host model drives the link at a 15 ns period
`timescale 1ns/1ps
`default_nettype none
module flash_status_and_write_enable_tb_top;
  localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
  localparam logic [15:0] PART = 16'h01C3; // arbitrary value
  int failures = 0;
  int check_count = 0;
  int seed = 2;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, cs_n, mosi, miso;
  logic [15:0] status, v;
  logic [15:0] model = 16'h0000;
  logic [23:0] rx;
  logic io0;
  logic [1:0] oe, oe_seen;
  logic [15:0] pair;
  // ==========================================================
  // design and host
  initial forever #2 clk = ~clk;
  flash_status_core #(.MAKER_ID(MAKER), .PART_ID(PART)) i_dut (.CLOCK_IN(clk), .NRST_IN(rst_n),
    .SCLK_IN(sclk), .CS_N_IN(cs_n), .IO0_IN(mosi), .IO0_OUT(io0), .IO0_OE_OUT(oe[0]), .IO1_IN(1'b0),
    .IO1_OUT(miso), .IO1_OE_OUT(oe[1]), .IO2_IN(1'b1), .IO2_OUT(), .IO2_OE_OUT(), .IO3_IN(1'b1),
    .IO3_OUT(), .IO3_OE_OUT(), .STATUS_WORD_OUT(status));
  flash_host_model i_host (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));
  // lane pairs and enables as the host would sample them on rising link clock
  always @(posedge sclk)
  begin
    pair <= {pair[13:0], miso, io0};
    oe_seen <= oe;
  end
  // ==========================================================
  // helpers
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic op(input logic [7:0] code, input int n);
    i_host.frame({code, 24'h00_0000}, 8, n, rx);
  endtask
  task automatic upd(input logic [15:0] d);
    i_host.frame({flash_status_pkg::OP_STATUS_UPDATE, d[7:0], d[15:8], 8'h00}, 24, 0, rx);
  endtask
  // otp locks only accumulate; halted flags untouched, busy and latch read 0
  function automatic logic [15:0] after_update(input logic [15:0] o, input logic [15:0] d);
    after_update = {o[15], d[14], o[13:11] | d[13:11], o[10], d[9:2], 2'b00};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(24'(status), 24'(model));
    op(flash_status_pkg::OP_ID_READOUT, 24);
    check(rx, {MAKER, PART});
    i_host.frame({flash_status_pkg::OP_LEGACY_ID, 24'h00_0001}, 32, 16, rx);
    check(rx, {8'h00, PART[7:0], MAKER});
    // a0 left at 0, so the dual answer opens with the maker byte
    i_host.frame({flash_status_pkg::OP_TWO_LANE_ID, 24'h00_0000}, 24, 4, rx);
    check(24'(pair[7:0]), 24'(MAKER));
    check(24'(oe_seen), 24'h00_0003);
    op(flash_status_pkg::OP_WRITE_UNLOCK, 0);
    model[1] = 1'b1;
    op(flash_status_pkg::OP_STATUS_LO, 8);
    check(24'(rx[7:0]), 24'(model[7:0]));
    op(flash_status_pkg::OP_WRITE_RELOCK, 0);
    model[1] = 1'b0;
    check(24'(status), 24'(model));
    upd(16'h007C);
    check(24'(status), 24'(model));
    for (int i = 0; i < 6; i++)
    begin
      // lock bits kept clear so later writes stay possible
      v = 16'($random(seed)) & 16'h7A7C;
      op(flash_status_pkg::OP_WRITE_UNLOCK, 0);
      upd(v);
      op(flash_status_pkg::OP_STATUS_LO, 8);
      check(24'(rx[1:0]), 24'h00_0003);
      repeat (260) @(posedge clk);
      model = after_update(model, v);
      check(24'(status), 24'(model));
      op(flash_status_pkg::OP_STATUS_HI, 8);
      check(24'(rx[7:0]), 24'(model[15:8]));
    end
    op(flash_status_pkg::OP_VOL_UNLOCK, 0);
    upd(16'h0004);
    model = after_update(model, 16'h0004);
    check(24'(status), 24'(model));
    // protect bits now nonzero, so whole-array erase must be ignored
    op(flash_status_pkg::OP_WRITE_UNLOCK, 0);
    model[1] = 1'b1;
    op(flash_status_pkg::OP_CHIP_CLEAR_A, 0);
    check(24'(status), 24'(model));
    i_host.frame({flash_status_pkg::OP_OTP_CLEAR, 24'h01_1000}, 32, 0, rx);
    check(24'(status), 24'(model));
    i_host.frame({flash_status_pkg::OP_PAGE_CLEAR, 24'h00_0100}, 32, 0, rx);
    op(flash_status_pkg::OP_SUSPEND_A, 0);
    model[15] = 1'b1;
    check(24'(status), 24'(model));
    op(flash_status_pkg::OP_RESUME_B, 0);
    model[15] = 1'b0;
    model[0] = 1'b1;
    check(24'(status), 24'(model));
    repeat (1010) @(posedge clk);
    model[1:0] = 2'b00;
    check(24'(status), 24'(model));
    op(flash_status_pkg::OP_WRITE_UNLOCK, 0);
    upd(16'h0100);
    repeat (260) @(posedge clk);
    model = after_update(model, 16'h0100);
    check(24'(status), 24'(model));
    op(flash_status_pkg::OP_WRITE_UNLOCK, 0);
    upd(16'h0000);
    model[1] = 1'b1;
    check(24'(status), 24'(model));
    op(flash_status_pkg::OP_RESET_ARM, 0);
    op(flash_status_pkg::OP_RESET, 0);
    model[1] = 1'b0;
    check(24'(status), 24'(model));
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(24'(status), 24'h00_0000);
    report_and_stop();
  end
  initial
  begin
    #200000;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
